// ===== core/spa_pkg.sv
// Package for the sweep position address tracker.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
`default_nettype none
package spa_pkg;

	// ------------------------------------------------------------
	// Widths and timing
	// ------------------------------------------------------------
	localparam int SPA_AW = 12;
	localparam int SPA_CLK_NS = 50;
	localparam int SPA_TICK_DIV = 40;
	localparam int SPA_SLOW_NS = 18000;
	localparam int SPA_FAST_NS = 1600;
	localparam int SPA_SLOW_CYC = (SPA_SLOW_NS + SPA_CLK_NS - 1) / SPA_CLK_NS;
	localparam int SPA_FAST_CYC = (SPA_FAST_NS + SPA_CLK_NS - 1) / SPA_CLK_NS;
	localparam logic [SPA_AW-1:0] SPA_ADDR_MAX = 12'hFFF;
	localparam logic [SPA_AW-1:0] SPA_ADDR_RST = 12'h000;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] SPA_CTRL_OFS = 4'h0;
	localparam logic [3:0] SPA_STAT_OFS = 4'h4;
	localparam int SPA_CTRL_SRC_BIT = 0;
	localparam int SPA_CTRL_FAST_BIT = 1;
	localparam int SPA_CTRL_GAIN_LSB = 2;
	localparam int SPA_STAT_RTR_BIT = 12;
	localparam int SPA_STAT_ADV_BIT = 13;
	localparam logic [2:0] SPA_GAIN_MAX = 3'h4;
	localparam logic [2:0] SPA_GAIN_RST = 3'h1;

	// Synchronised input bit positions
	localparam int SPA_NIN = 6;
	localparam int SPA_IN_TUP = 0;
	localparam int SPA_IN_TDN = 1;
	localparam int SPA_IN_RUP = 2;
	localparam int SPA_IN_RDN = 3;
	localparam int SPA_IN_END = 4;
	localparam int SPA_IN_BOT = 5;

	// Software control fields
	typedef struct packed {
		logic [2:0] gain;
		logic fast;
		logic ext_src;
	} spa_ctrl_t;

	typedef enum logic {SPA_IDLE, SPA_HOLD} spa_tmr_t;
endpackage
`default_nettype wire

// ===== core/spa_tracker.sv
// Sweep position address tracker: comparator-driven 12-bit tracking counter.
// Assumes analog comparators on asynchronous pins and a classic Wishbone master.
//
// Function
// - Address derives from the scope ramp or an external frequency-proportional sweep.
// - Comparator decisions latch on the 500 kHz tick; timer pulse clears them.
// - Timer sets least step interval: 18 us slow, 1.6 us fast.
// - Each latched result gives one up or down step toward the sweep.
// - An up step starts the timer, whose clear pulse resets the latch.
// - In retrace the trace counter loads and passes the retrace counter value.
// - Retrace ticks step the retrace counter to the held bottom level, then hold.
// - After retrace, normal comparator-driven tracking resumes.
// - Bottom comparator gives trace_began_pulse when the sweep leaves its bottom.
// - The trace_began_pulse clears the retrace latch.
// - sweep_advancing is high only during forward trace.
// - sweep_advancing is provided to the input boards.
// - Forward trace start makes the bottom sampler capture and hold.
// - External gain selectable to 0.5, 1, 2, 3 or 4.
// - Retrace asserts at sweep end and deasserts on trace_began_pulse.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module spa_tracker
	import spa_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic trk_up_i,
	input wire logic trk_dn_i,
	input wire logic rtr_up_i,
	input wire logic rtr_dn_i,
	input wire logic sweep_end_i,
	input wire logic bottom_above_i,
	output logic [SPA_AW-1:0] dac_code_o,
	output logic ext_src_sel_o,
	output logic [2:0] ext_gain_o,
	output logic retrace_o,
	output logic trace_began_pulse_o,
	output logic sampler_track_o,
	output logic sweep_advancing_o
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [SPA_NIN-1:0] pin_raw;
	logic [SPA_NIN-1:0] s1_r, s2_r, s3_r, flt_r;
	logic [SPA_NIN-1:0] flt_nxt;

	assign pin_raw = {bottom_above_i, sweep_end_i, rtr_dn_i, rtr_up_i, trk_dn_i, trk_up_i};

	// A bit changes once the second and third stages agree
	genvar gi;
	generate
		for (gi = 0; gi < SPA_NIN; gi++) begin : g_sync
			always_comb begin
				flt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : flt_r[gi];
			end
		end
	endgenerate

	// Synchroniser stages
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			flt_r <= '0;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			flt_r <= flt_nxt;
		end
	end

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	spa_ctrl_t ctrl_r, ctrl_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic [SPA_AW-1:0] dac_r, dac_nxt;
	logic retrace_r, retrace_nxt;
	logic adv_r, adv_nxt;
	logic bus_req;

	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;

	// Decode, write control, build read data; unmapped reads zero
	always_comb begin
		ctrl_nxt = ctrl_r;
		rdat_nxt = rdat_r;
		ack_nxt = bus_req;
		if (bus_req && wb_we_i && wb_adr_i == SPA_CTRL_OFS && wb_sel_i[0]) begin
			ctrl_nxt.ext_src = wb_dat_i[SPA_CTRL_SRC_BIT];
			ctrl_nxt.fast = wb_dat_i[SPA_CTRL_FAST_BIT];
			// Codes above the largest gain clamp to it
			if (wb_dat_i[SPA_CTRL_GAIN_LSB +: 3] > SPA_GAIN_MAX) begin
				ctrl_nxt.gain = SPA_GAIN_MAX;
			end else begin
				ctrl_nxt.gain = wb_dat_i[SPA_CTRL_GAIN_LSB +: 3];
			end
		end
		if (bus_req && !wb_we_i) begin
			rdat_nxt = 32'h0000_0000;
			if (wb_adr_i == SPA_CTRL_OFS) begin
				rdat_nxt[SPA_CTRL_SRC_BIT] = ctrl_r.ext_src;
				rdat_nxt[SPA_CTRL_FAST_BIT] = ctrl_r.fast;
				rdat_nxt[SPA_CTRL_GAIN_LSB +: 3] = ctrl_r.gain;
			end else if (wb_adr_i == SPA_STAT_OFS) begin
				rdat_nxt[SPA_AW-1:0] = dac_r;
				rdat_nxt[SPA_STAT_RTR_BIT] = retrace_r;
				rdat_nxt[SPA_STAT_ADV_BIT] = adv_r;
			end
		end
	end

	// Bus registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= '{gain: SPA_GAIN_RST, fast: 1'h0, ext_src: 1'h0};
			ack_r <= 1'h0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ctrl_r <= ctrl_nxt;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	// ------------------------------------------------------------
	// 500 kHz system tick and rate-limit timer
	// ------------------------------------------------------------
	logic [5:0] div_r, div_nxt;
	logic tick;
	spa_tmr_t tmr_st_r, tmr_st_nxt;
	logic [8:0] tmr_r, tmr_nxt;
	logic [1:0] latch_r, latch_nxt; // [1] down, [0] up
	logic step_up, step_dn, clr_pulse;

	assign tick = (div_r == 6'(SPA_TICK_DIV - 1));
	assign clr_pulse = (tmr_st_r == SPA_HOLD) && (tmr_r == 9'h000);
	assign step_up = latch_nxt[0] & ~latch_r[0];
	assign step_dn = latch_nxt[1] & ~latch_r[1];

	// Tick divider, step latches and interval timer
	always_comb begin
		div_nxt = tick ? 6'h00 : div_r + 6'h01;
		latch_nxt = latch_r;
		tmr_st_nxt = tmr_st_r;
		tmr_nxt = tmr_r;
		if (clr_pulse) begin
			latch_nxt = 2'h0;
		end else if (tick && !retrace_r && latch_r == 2'h0) begin
			if (flt_r[SPA_IN_TUP]) begin
				latch_nxt = 2'h1;
			end else if (flt_r[SPA_IN_TDN]) begin
				latch_nxt = 2'h2;
			end
		end
		case (tmr_st_r)
			SPA_IDLE: begin
				// Any step arms the timer, so downward steps obey the same pace
				if (step_up || step_dn) begin
					tmr_st_nxt = SPA_HOLD;
					tmr_nxt = ctrl_r.fast ? 9'(SPA_FAST_CYC - 2) : 9'(SPA_SLOW_CYC - 2);
				end
			end
			SPA_HOLD: begin
				if (tmr_r == 9'h000) begin
					tmr_st_nxt = SPA_IDLE;
				end else begin
					tmr_nxt = tmr_r - 9'h001;
				end
			end
			default: tmr_st_nxt = SPA_IDLE;
		endcase
	end

	// Timer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= 6'h00;
			latch_r <= 2'h0;
			tmr_st_r <= SPA_IDLE;
			tmr_r <= 9'h000;
		end else begin
			div_r <= div_nxt;
			latch_r <= latch_nxt;
			tmr_st_r <= tmr_st_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	// ------------------------------------------------------------
	// Trace and retrace counters
	// ------------------------------------------------------------
	logic [SPA_AW-1:0] trc_r, trc_nxt, rtc_r, rtc_nxt;
	logic end_d_r, bot_d_r, began_r, began_nxt, samp_r, samp_nxt;
	logic began;

	assign began = retrace_r & flt_r[SPA_IN_BOT] & ~bot_d_r;

	// Counting, retrace latch, forward-trace indication
	always_comb begin
		trc_nxt = trc_r;
		rtc_nxt = rtc_r;
		retrace_nxt = retrace_r;
		if (retrace_r) begin
			trc_nxt = rtc_r;
			if (tick && flt_r[SPA_IN_RDN] && rtc_r != SPA_ADDR_RST) begin
				rtc_nxt = rtc_r - 12'h001;
			end else if (tick && flt_r[SPA_IN_RUP] && rtc_r != SPA_ADDR_MAX) begin
				rtc_nxt = rtc_r + 12'h001;
			end
		end else begin
			rtc_nxt = trc_r;
			if (step_up && trc_r != SPA_ADDR_MAX) begin
				trc_nxt = trc_r + 12'h001;
			end else if (step_dn && trc_r != SPA_ADDR_RST) begin
				trc_nxt = trc_r - 12'h001;
			end
		end
		if (began) begin
			retrace_nxt = 1'h0;
		end else if (flt_r[SPA_IN_END] && !end_d_r) begin
			retrace_nxt = 1'h1;
		end
		dac_nxt = retrace_nxt ? rtc_nxt : trc_nxt;
		began_nxt = began;
		samp_nxt = retrace_nxt & ~flt_r[SPA_IN_BOT];
		adv_nxt = ~retrace_nxt & flt_r[SPA_IN_BOT];
	end

	// Counter registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trc_r <= SPA_ADDR_RST;
			rtc_r <= SPA_ADDR_RST;
			dac_r <= SPA_ADDR_RST;
			retrace_r <= 1'h0;
			end_d_r <= 1'h0;
			bot_d_r <= 1'h0;
			began_r <= 1'h0;
			samp_r <= 1'h0;
			adv_r <= 1'h0;
		end else begin
			trc_r <= trc_nxt;
			rtc_r <= rtc_nxt;
			dac_r <= dac_nxt;
			retrace_r <= retrace_nxt;
			end_d_r <= flt_r[SPA_IN_END];
			bot_d_r <= flt_r[SPA_IN_BOT];
			began_r <= began_nxt;
			samp_r <= samp_nxt;
			adv_r <= adv_nxt;
		end
	end

	// Outputs, all straight from flops
	assign wb_dat_o = rdat_r;
	assign wb_ack_o = ack_r;
	assign dac_code_o = dac_r;
	assign ext_src_sel_o = ctrl_r.ext_src;
	assign ext_gain_o = ctrl_r.gain;
	assign retrace_o = retrace_r;
	assign trace_began_pulse_o = began_r;
	assign sampler_track_o = samp_r;
	assign sweep_advancing_o = adv_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence up_step_s;
		step_up && !ctrl_r.fast;
	endsequence
	sequence held_s;
		(tmr_st_r == SPA_HOLD) [*8];
	endsequence

	slow_interval_a: assert property (@(posedge clk_i) disable iff (rst_i)
		up_step_s |=> held_s ##0 (tmr_r == 9'(SPA_SLOW_CYC - 9)))
		else $error("slow interval not loaded");
	latch_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		clr_pulse |=> latch_r == 2'h0)
		else $error("latch not cleared by timer");
	one_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		step_up |=> !step_up && trc_r == $past(trc_r) + 12'h001 || $past(trc_r) == SPA_ADDR_MAX)
		else $error("up step not taken once");
	top_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!retrace_r && trc_r == SPA_ADDR_MAX && !retrace_nxt |=> trc_r != SPA_ADDR_RST)
		else $error("address wrapped");
	retrace_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		retrace_r |=> trc_r == $past(rtc_r))
		else $error("trace counter not loaded");
	dac_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		retrace_r && $stable(retrace_r) |-> dac_code_o == rtc_r)
		else $error("dac not showing retrace value");
	began_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		began |=> !retrace_o ##0 trace_began_pulse_o ##1 !trace_began_pulse_o)
		else $error("trace began did not clear retrace");
	advance_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sweep_advancing_o |-> !retrace_o)
		else $error("advancing during retrace");
	no_step_rtr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		retrace_r && !tick |=> rtc_r == $past(rtc_r))
		else $error("retrace step off tick");
	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// ===== sim/spa_sweep_model.sv
// Partner model: sweep ramp and the comparator pairs that face the tracker.
// Assumes the bench gives the sweep and the held bottom level as 12-bit codes.
`timescale 1ns/1ps
`default_nettype none
module spa_sweep_model
	import spa_pkg::*;
(
	input wire logic clk_i,
	input wire logic [SPA_AW-1:0] sweep_i,
	input wire logic [SPA_AW-1:0] bottom_i,
	input wire logic [SPA_AW-1:0] dac_i,
	output logic trk_up_o,
	output logic trk_dn_o,
	output logic rtr_up_o,
	output logic rtr_dn_o
);
	// Comparators with one clock of settling; levels are unsigned, never below zero
	always_ff @(posedge clk_i) begin
		trk_up_o <= sweep_i > dac_i;
		trk_dn_o <= sweep_i < dac_i;
		rtr_up_o <= bottom_i > dac_i;
		rtr_dn_o <= bottom_i < dac_i;
	end
endmodule
`default_nettype wire

// ===== sim/sweep_position_address_tracker_tb_top.sv
// Bench for the sweep tracker: register bus, tracking, rate limit, retrace.
// Assumes the comparator model and a 50 ns clock.
`timescale 1ns/1ps
`default_nettype none
module sweep_position_address_tracker_tb_top;
	import spa_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [3:0] adr = 4'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat, q;
	logic ack, tu, td, ru, rd, rtr, tbp, smp, adv, src;
	logic [2:0] gain;
	logic [11:0] dac;
	logic [11:0] sweep = 12'h000;
	logic [11:0] bottom = 12'h000;
	logic send = 1'h0;
	logic above = 1'h0;
	int num_errors = 0;
	int cmp_count = 0;
	int n;

	// Clock
	initial begin
		forever #25 clk_i = ~clk_i;
	end

	spa_tracker uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .trk_up_i(tu), .trk_dn_i(td), .rtr_up_i(ru), .rtr_dn_i(rd),
		.sweep_end_i(send), .bottom_above_i(above), .dac_code_o(dac), .ext_src_sel_o(src),
		.ext_gain_o(gain), .retrace_o(rtr), .trace_began_pulse_o(tbp),
		.sampler_track_o(smp), .sweep_advancing_o(adv));

	spa_sweep_model model (.clk_i(clk_i), .sweep_i(sweep), .bottom_i(bottom), .dac_i(dac),
		.trk_up_o(tu), .trk_dn_o(td), .rtr_up_o(ru), .rtr_dn_o(rd));

	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic hang(input int c, input int lim);
		if (c >= lim) begin
			num_errors++;
			give_verdict();
		end
	endtask

	// One classic Wishbone cycle
	task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		@(posedge clk_i);
		for (k = 0; k < 20 && ack !== 1'h1; k++) @(posedge clk_i);
		hang(k, 20);
		r = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask

	// Moves the sweep, waits for the address to follow, keeps the shortest step spacing
	task automatic track(input logic [11:0] e, input int least);
		int k;
		int last;
		int mg;
		logic [11:0] prev;
		last = -1;
		mg = 1000;
		prev = dac;
		sweep <= e;
		for (k = 0; k < 5000 && dac !== e; k++) begin
			@(posedge clk_i);
			if (dac !== prev) begin
				if (last >= 0 && k - last < mg) begin
					mg = k - last;
				end
				last = k;
				prev = dac;
			end
		end
		hang(k, 5000);
		chk(32'(mg >= least), 32'h1);
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic t_reset();
		chk({12'h0, dac, src, gain, rtr, tbp, smp, adv}, 32'h0010);
		wb(1'h0, SPA_STAT_OFS, 4'hF, 32'h0, q);
		chk(q, 32'h0);
		wb(1'h0, 4'hC, 4'hF, 32'h0, q);
		chk(q, 32'h0);
		$display("t_reset done");
	endtask

	task automatic t_regs();
		for (n = 0; n < 8; n++) begin
			wb(1'h1, SPA_CTRL_OFS, 4'hF, {27'h0, n[2:0], 2'h1}, q);
			repeat (2) @(posedge clk_i);
			chk({29'h0, gain}, (n > 4) ? 32'h4 : 32'(n));
			chk({31'h0, src}, 32'h1);
		end
		wb(1'h1, SPA_CTRL_OFS, 4'h2, 32'h0, q);
		wb(1'h1, 4'hC, 4'hF, 32'h0, q);
		repeat (2) @(posedge clk_i);
		chk({31'h0, src}, 32'h1);
		wb(1'h0, SPA_CTRL_OFS, 4'hF, 32'h0, q);
		chk(q, 32'h11);
		$display("t_regs done");
	endtask

	task automatic t_rate();
		wb(1'h1, SPA_CTRL_OFS, 4'h1, 32'h6, q);
		track(12'h006, SPA_FAST_CYC);
		wb(1'h0, SPA_STAT_OFS, 4'hF, 32'h0, q);
		chk(q, 32'h6);
		track(12'h002, SPA_FAST_CYC);
		wb(1'h1, SPA_CTRL_OFS, 4'h1, 32'h4, q);
		track(12'h004, SPA_SLOW_CYC);
		$display("t_rate done");
	endtask

	task automatic t_retrace();
		wb(1'h1, SPA_CTRL_OFS, 4'h1, 32'h6, q);
		above <= 1'h1;
		track(12'h009, SPA_FAST_CYC);
		chk({31'h0, adv}, 32'h1);
		bottom <= 12'h002;
		send <= 1'h1;
		for (n = 0; n < 50 && rtr !== 1'h1; n++) @(posedge clk_i);
		hang(n, 50);
		chk({31'h0, adv}, 32'h0);
		sweep <= 12'h000;
		above <= 1'h0;
		send <= 1'h0;
		for (n = 0; n < 2000 && dac !== 12'h002; n++) @(posedge clk_i);
		hang(n, 2000);
		repeat (200) @(posedge clk_i);
		chk({19'h0, smp, dac}, 32'h1002);
		wb(1'h0, SPA_STAT_OFS, 4'hF, 32'h0, q);
		chk(q, 32'h1002);
		sweep <= 12'h002;
		above <= 1'h1;
		for (n = 0; n < 50 && tbp !== 1'h1; n++) @(posedge clk_i);
		hang(n, 50);
		chk({30'h0, rtr, adv}, 32'h1);
		@(posedge clk_i);
		chk({30'h0, tbp, smp}, 32'h0);
		track(12'h005, SPA_FAST_CYC);
		$display("t_retrace done");
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		t_reset();
		t_regs();
		t_rate();
		t_retrace();
		// Mid-run reset with the pins idle, then the reset state again
		sweep <= 12'h000;
		above <= 1'h0;
		rst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		t_reset();
		give_verdict();
	end
endmodule
`default_nettype wire
